// >>> src/mmc_map.svh
`ifndef MMC_MAP_SVH
`define MMC_MAP_SVH
// EEPROM serial commands
`define MMC_EEP_CMD_READ 8'h03
`define MMC_EEP_CMD_WREN 8'h06
`define MMC_EEP_CMD_WRITE 8'h02
// EEPROM layout
`define MMC_EEP_ADDR_COEF 8'h00
`define MMC_EEP_ADDR_TOTAL 8'h40
`define MMC_EEP_ADDR_CONV 8'h50
// Save overlays the stored total so the next start-up reloads it
`define MMC_EEP_ADDR_SAVE `MMC_EEP_ADDR_TOTAL
// Metering chip register map
`define MMC_CHIP_WRITE_BIT 8'h80
`define MMC_CHIP_ADDR_ENERGY 8'h02
`define MMC_CHIP_ADDR_COEF 8'h04
// Field sizes in bytes, and number of coefficients
`define MMC_TOTAL_BYTES 11
`define MMC_ENERGY_BYTES 3
`define MMC_CONV_BYTES 4
`define MMC_COEF_BYTES 2
`define MMC_NUM_COEF 8
// Binary point of the scaled total
`define MMC_FRAC_BITS 40
// Timing
`define MMC_CLK_PERIOD_NS 40
`define MMC_PD_TIME_NS 1400000
`define MMC_PD_CYCLES (`MMC_PD_TIME_NS / `MMC_CLK_PERIOD_NS)
`define MMC_SPI_HALF 4
`endif

// >>> src/mmc_pkg.sv
package mmc_pkg;
    typedef enum logic [3:0] {
        MMC_ST_RESET,
        MMC_ST_CAL,
        MMC_ST_COEF_RD,
        MMC_ST_COEF_WR,
        MMC_ST_TOTAL_RD,
        MMC_ST_CONV_RD,
        MMC_ST_RUN_RD,
        MMC_ST_PD_RD,
        MMC_ST_PD_WREN,
        MMC_ST_PD_WR,
        MMC_ST_HALT
    } mmc_state_e;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic cs_chip_n;
        logic cs_eep_n;
    } mmc_spi_s;
endpackage

// >>> src/mmc_top.sv
// Functional notes
// - Sample mode select at power-up; low calibrates
// - Relay every stored coefficient into metering chip
// - Load stored total and conversion coefficient
// - Running total register is eleven bytes
// - Normal measuring starts only after initialization
// - Read energy, scale, add to running total
// - Show updated kilowatt-hour total after each accumulation
// - Irq or sag in normal mode enters power-down
// - Calibration mode floats all four SPI output pins
// - Power-down save completes within 1.4 ms
// - Save running total and chip's pending energy
// - Next power-up reloads the saved total (not the saved energy), resumes normal
// - Energy read: select chip, command, clock in
`timescale 1ns/10ps
`include "mmc_map.svh"
module mmc_top #(
    parameter int NUM_COEF = `MMC_NUM_COEF,
    parameter int SPI_HALF = `MMC_SPI_HALF,
    parameter int PD_CYCLES = `MMC_PD_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode_select_input,
    input wire logic irq_n,
    input wire logic sag_n,
    input wire logic miso,
    output mmc_pkg::mmc_spi_s spi_o,
    output mmc_pkg::mmc_spi_s spi_oe,
    output mmc_pkg::mmc_state_e mode,
    output logic [8*`MMC_TOTAL_BYTES-`MMC_FRAC_BITS-1:0] disp_kwh,
    output logic disp_stb,
    output logic save_done,
    output logic save_late
);
    localparam int TB = 8 * `MMC_TOTAL_BYTES;
    localparam int EB = 8 * `MMC_ENERGY_BYTES;
    localparam int CB = 8 * `MMC_CONV_BYTES;
    localparam int KB = 8 * `MMC_COEF_BYTES;
    localparam int FW = 128;

    logic [1:0] rst_q;
    logic rst_s_n;
    logic [1:0] mode_q, irq_q, sag_q, miso_q;

    mmc_pkg::mmc_state_e state_r, state_nxt;
    logic [TB-1:0] total_r, total_nxt;
    logic [CB-1:0] conv_r, conv_nxt;
    logic [EB-1:0] energy_r, energy_nxt;
    logic [KB-1:0] coef_r, coef_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic [FW-1:0] tx_r, tx_nxt, rx_r, rx_nxt;
    logic [7:0] bits_r, bits_nxt;
    logic [7:0] div_r, div_nxt;
    logic busy_r, busy_nxt, sel_chip_r, sel_chip_nxt, launched_r, launched_nxt;
    logic [1:0] strap_r, strap_nxt;
    logic [31:0] pd_cnt_r, pd_cnt_nxt;
    mmc_pkg::mmc_spi_s spi_r, spi_nxt, oe_r, oe_nxt;
    logic [TB-`MMC_FRAC_BITS-1:0] kwh_r, kwh_nxt;
    logic stb_r, stb_nxt, done_r, done_nxt, late_r, late_nxt;
    logic tick, frame_done;
    logic [TB-1:0] product;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_s_n = rst_q[1];

    always_ff @(posedge clk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            mode_q <= 2'h3;
            irq_q <= 2'h3;
            sag_q <= 2'h3;
            miso_q <= 2'h0;
        end
        else
        begin
            mode_q <= {mode_q[0], mode_select_input};
            irq_q <= {irq_q[0], irq_n};
            sag_q <= {sag_q[0], sag_n};
            miso_q <= {miso_q[0], miso};
        end
    end

    assign tick = (div_r == 8'(SPI_HALF - 1));
    assign frame_done = busy_r && tick && spi_r.sclk && (bits_r == 8'h01);
    assign product = TB'(rx_r[EB-1:0]) * TB'(conv_r);

    always_comb
    begin
        state_nxt = state_r;
        total_nxt = total_r;
        conv_nxt = conv_r;
        energy_nxt = energy_r;
        coef_nxt = coef_r;
        idx_nxt = idx_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        bits_nxt = bits_r;
        div_nxt = 8'h00;
        busy_nxt = busy_r;
        sel_chip_nxt = sel_chip_r;
        launched_nxt = launched_r;
        strap_nxt = strap_r;
        pd_cnt_nxt = pd_cnt_r;
        kwh_nxt = kwh_r;
        stb_nxt = 1'b0;
        done_nxt = done_r;
        late_nxt = late_r;
        spi_nxt = spi_r;
        // Frame engine: shift out on falling edge, sample on rising edge
        if (busy_r)
        begin
            div_nxt = tick ? 8'h00 : div_r + 8'h01;
            if (tick && !spi_r.sclk)
            begin
                spi_nxt.sclk = 1'b1;
                rx_nxt = {rx_r[FW-2:0], miso_q[1]};
            end
            else if (tick)
            begin
                spi_nxt.sclk = 1'b0;
                tx_nxt = {tx_r[FW-2:0], 1'b0};
                bits_nxt = bits_r - 8'h01;
                if (bits_r == 8'h01)
                    busy_nxt = 1'b0;
            end
        end
        if (frame_done)
            launched_nxt = 1'b0;
        case (state_r)
            mmc_pkg::MMC_ST_RESET:
            begin
                strap_nxt = strap_r + 2'h1;
                if (strap_r == 2'h3)
                    state_nxt = mode_q[1] ? mmc_pkg::MMC_ST_COEF_RD
                                          : mmc_pkg::MMC_ST_CAL;
            end
            mmc_pkg::MMC_ST_CAL:
                state_nxt = mmc_pkg::MMC_ST_CAL;
            mmc_pkg::MMC_ST_COEF_RD:
            begin
                if (!launched_r)
                begin
                    tx_nxt = {`MMC_EEP_CMD_READ, 8'(`MMC_EEP_ADDR_COEF + 2 * idx_r),
                              {(FW-16){1'b0}}};
                    bits_nxt = 8'(16 + KB);
                end
                else if (frame_done)
                begin
                    coef_nxt = rx_r[KB-1:0];
                    state_nxt = mmc_pkg::MMC_ST_COEF_WR;
                end
            end
            mmc_pkg::MMC_ST_COEF_WR:
            begin
                if (!launched_r)
                begin
                    tx_nxt = {`MMC_CHIP_WRITE_BIT | 8'(`MMC_CHIP_ADDR_COEF + idx_r), coef_r,
                              {(FW-8-KB){1'b0}}};
                    bits_nxt = 8'(8 + KB);
                end
                else if (frame_done)
                begin
                    idx_nxt = idx_r + 8'h01;
                    if (idx_r == 8'(NUM_COEF - 1))
                        state_nxt = mmc_pkg::MMC_ST_TOTAL_RD;
                    else
                        state_nxt = mmc_pkg::MMC_ST_COEF_RD;
                end
            end
            mmc_pkg::MMC_ST_TOTAL_RD:
            begin
                if (!launched_r)
                begin
                    tx_nxt = {`MMC_EEP_CMD_READ, `MMC_EEP_ADDR_TOTAL, {(FW-16){1'b0}}};
                    bits_nxt = 8'(16 + TB);
                end
                else if (frame_done)
                begin
                    total_nxt = rx_r[TB-1:0];
                    state_nxt = mmc_pkg::MMC_ST_CONV_RD;
                end
            end
            mmc_pkg::MMC_ST_CONV_RD:
            begin
                if (!launched_r)
                begin
                    tx_nxt = {`MMC_EEP_CMD_READ, `MMC_EEP_ADDR_CONV, {(FW-16){1'b0}}};
                    bits_nxt = 8'(16 + CB);
                end
                else if (frame_done)
                begin
                    conv_nxt = rx_r[CB-1:0];
                    state_nxt = mmc_pkg::MMC_ST_RUN_RD;
                end
            end
            mmc_pkg::MMC_ST_RUN_RD, mmc_pkg::MMC_ST_PD_RD:
            begin
                if (!launched_r)
                begin
                    tx_nxt = {`MMC_CHIP_ADDR_ENERGY, {(FW-8){1'b0}}};
                    bits_nxt = 8'(8 + EB);
                end
                else if (frame_done)
                    energy_nxt = rx_r[EB-1:0];
            end
            mmc_pkg::MMC_ST_PD_WREN:
            begin
                if (!launched_r)
                begin
                    tx_nxt = {`MMC_EEP_CMD_WREN, {(FW-8){1'b0}}};
                    bits_nxt = 8'h08;
                end
                else if (frame_done)
                    state_nxt = mmc_pkg::MMC_ST_PD_WR;
            end
            mmc_pkg::MMC_ST_PD_WR:
            begin
                if (!launched_r)
                begin
                    tx_nxt = {`MMC_EEP_CMD_WRITE, `MMC_EEP_ADDR_SAVE, total_r, energy_r};
                    bits_nxt = 8'(16 + TB + EB);
                end
                else if (frame_done)
                begin
                    done_nxt = 1'b1;
                    late_nxt = (pd_cnt_r >= 32'(PD_CYCLES));
                    state_nxt = mmc_pkg::MMC_ST_HALT;
                end
            end
            mmc_pkg::MMC_ST_HALT:
                state_nxt = mmc_pkg::MMC_ST_HALT;
            default:
                state_nxt = mmc_pkg::MMC_ST_RESET;
        endcase
        if (state_r == mmc_pkg::MMC_ST_RUN_RD && launched_r && frame_done)
        begin
            total_nxt = total_r + product;
            kwh_nxt = total_nxt[TB-1:`MMC_FRAC_BITS];
            stb_nxt = 1'b1;
        end
        if (state_r == mmc_pkg::MMC_ST_PD_RD && launched_r && frame_done)
            state_nxt = mmc_pkg::MMC_ST_PD_WREN;
        // Power fail is checked only between reads; save ignores it afterwards
        if (state_r == mmc_pkg::MMC_ST_RUN_RD && !launched_r && (!irq_q[1] || !sag_q[1]))
            state_nxt = mmc_pkg::MMC_ST_PD_RD;
        else if (state_r != mmc_pkg::MMC_ST_RESET && state_r != mmc_pkg::MMC_ST_CAL &&
                 state_r != mmc_pkg::MMC_ST_HALT && !launched_r)
        begin
            launched_nxt = 1'b1;
            busy_nxt = 1'b1;
            sel_chip_nxt = (state_r == mmc_pkg::MMC_ST_COEF_WR) ||
                           (state_r == mmc_pkg::MMC_ST_RUN_RD) ||
                           (state_r == mmc_pkg::MMC_ST_PD_RD);
        end
        if (state_r == mmc_pkg::MMC_ST_PD_RD || state_r == mmc_pkg::MMC_ST_PD_WREN ||
            state_r == mmc_pkg::MMC_ST_PD_WR)
            pd_cnt_nxt = pd_cnt_r + 32'h1;
        spi_nxt.mosi = tx_nxt[FW-1];
        spi_nxt.cs_chip_n = !(busy_nxt && sel_chip_nxt);
        spi_nxt.cs_eep_n = !(busy_nxt && !sel_chip_nxt);
        oe_nxt = (state_nxt == mmc_pkg::MMC_ST_CAL || state_nxt == mmc_pkg::MMC_ST_RESET)
                 ? 4'h0 : 4'hF;
    end

    always_ff @(posedge clk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            state_r <= mmc_pkg::MMC_ST_RESET;
            total_r <= '0;
            conv_r <= '0;
            energy_r <= '0;
            coef_r <= '0;
            idx_r <= 8'h00;
            tx_r <= '0;
            rx_r <= '0;
            bits_r <= 8'h00;
            div_r <= 8'h00;
            busy_r <= 1'b0;
            sel_chip_r <= 1'b0;
            launched_r <= 1'b0;
            strap_r <= 2'h0;
            pd_cnt_r <= 32'h0;
            spi_r <= 4'h3;
            oe_r <= 4'h0;
            kwh_r <= '0;
            stb_r <= 1'b0;
            done_r <= 1'b0;
            late_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            total_r <= total_nxt;
            conv_r <= conv_nxt;
            energy_r <= energy_nxt;
            coef_r <= coef_nxt;
            idx_r <= idx_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            bits_r <= bits_nxt;
            div_r <= div_nxt;
            busy_r <= busy_nxt;
            sel_chip_r <= sel_chip_nxt;
            launched_r <= launched_nxt;
            strap_r <= strap_nxt;
            pd_cnt_r <= pd_cnt_nxt;
            spi_r <= spi_nxt;
            oe_r <= oe_nxt;
            kwh_r <= kwh_nxt;
            stb_r <= stb_nxt;
            done_r <= done_nxt;
            late_r <= late_nxt;
        end
    end

    assign spi_o = spi_r;
    assign spi_oe = oe_r;
    assign mode = state_r;
    assign disp_kwh = kwh_r;
    assign disp_stb = stb_r;
    assign save_done = done_r;
    assign save_late = late_r;
endmodule // mmc_top

// >>> testbench/mmc_top_properties.sv
`timescale 1ns/10ps
module mmc_top_properties #(
    parameter int NUM_COEF = 8,
    parameter int SPI_HALF = 4,
    parameter int PD_CYCLES = 35000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irq_n,
    input wire logic sag_n,
    input mmc_pkg::mmc_spi_s spi_o,
    input mmc_pkg::mmc_spi_s spi_oe,
    input mmc_pkg::mmc_state_e mode,
    input wire logic [47:0] disp_kwh,
    input wire logic disp_stb,
    input wire logic save_done
);
    int pd_cnt_r;
    int pd_cnt_nxt;
    logic in_pd;
    assign in_pd = mode inside {mmc_pkg::MMC_ST_PD_RD, mmc_pkg::MMC_ST_PD_WREN,
        mmc_pkg::MMC_ST_PD_WR};
    // Cycles spent in the save so far
    always_comb pd_cnt_nxt = in_pd ? pd_cnt_r + 1 : 0;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            pd_cnt_r <= 0;
        else
            pd_cnt_r <= pd_cnt_nxt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_sclk_high;
        spi_o.sclk [*4];
    endsequence
    sequence s_fault;
        (mode == mmc_pkg::MMC_ST_RUN_RD && !(irq_n && sag_n)) [*3];
    endsequence
    chk_cal_float: assert property (
        mode == mmc_pkg::MMC_ST_CAL |-> spi_oe == '0) else $error("pins driven in calibration");
    chk_stb_run: assert property (
        disp_stb |-> $past(mode) == mmc_pkg::MMC_ST_RUN_RD) else $error("display outside normal");
    chk_stb_pulse: assert property (
        disp_stb |=> !disp_stb) else $error("display strobe too long");
    chk_kwh_hold: assert property (
        $changed(disp_kwh) |-> disp_stb) else $error("display changed without strobe");
    chk_pd_entry: assert property (
        s_fault |-> ##[0:300] mode == mmc_pkg::MMC_ST_PD_RD) else $error("no power-down entry");
    chk_save_bound: assert property (
        pd_cnt_r < PD_CYCLES) else $error("save took too long");
    chk_save_flag: assert property (
        $fell(in_pd) |-> ##[0:1] save_done) else $error("save end without done flag");
    chk_pd_stay: assert property (
        in_pd |=> in_pd || mode == mmc_pkg::MMC_ST_HALT) else $error("save interrupted");
    chk_sclk_half: assert property (
        $rose(spi_o.sclk) |-> s_sclk_high ##1 !spi_o.sclk) else $error("clock half period wrong");
    chk_sclk_idle: assert property (
        spi_o.cs_chip_n && spi_o.cs_eep_n |-> !spi_o.sclk) else $error("clock outside frame");
endmodule // mmc_top_properties
bind mmc_top mmc_top_properties #(.NUM_COEF(NUM_COEF), .SPI_HALF(SPI_HALF),
    .PD_CYCLES(PD_CYCLES)) mmc_top_properties_inst (.clk(clk), .rst_n(rst_n),
    .irq_n(irq_n), .sag_n(sag_n), .spi_o(spi_o), .spi_oe(spi_oe), .mode(mode),
    .disp_kwh(disp_kwh), .disp_stb(disp_stb), .save_done(save_done));

// >>> testbench/mmc_far.sv
`timescale 1ns/10ps
`include "mmc_map.svh"
module mmc_far (
    input wire logic clk,
    input mmc_pkg::mmc_spi_s spi,
    output logic miso
);
    logic [7:0] eep [256];
    logic [7:0] coef [32];
    logic [23:0] energy;
    logic [95:0] tx;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] adr;
    logic ps = 1'b0;
    int nb = 0;
    initial miso = 1'b0;
    always @(posedge clk)
    begin
        if (spi.cs_chip_n && spi.cs_eep_n)
        begin
            nb = 0;
            miso <= ~miso; // Released line carries no stale data
        end
        else if (spi.sclk && !ps)
        begin
            sh = {sh[6:0], spi.mosi};
            nb++;
            if (nb == 8)
                cmd = sh;
            if (nb % 8 == 0 && !spi.cs_eep_n)
            begin
                if (nb == 16)
                begin
                    adr = sh;
                    for (int i = 0; i < 12; i++)
                        tx[95-8*i -: 8] = eep[adr+i];
                end
                else if (nb > 16 && cmd == `MMC_EEP_CMD_WRITE)
                    eep[adr+nb/8-3] = sh;
            end
            else if (nb == 8 && cmd == `MMC_CHIP_ADDR_ENERGY)
                tx[95 -: 24] = energy;
            else if (nb % 8 == 0 && nb > 8 && cmd[7])
                coef[2*(cmd[6:0]-4)+nb/8-2] = sh;
        end
        else if (!spi.sclk && ps)
        begin
            miso <= tx[95];
            tx = tx << 1;
        end
        ps = spi.sclk;
    end
endmodule // mmc_far

// >>> testbench/testbench.sv
`timescale 1ns/10ps
`include "mmc_map.svh"
module testbench;
    logic clk, rst_n, strap, irq_n, sag_n, miso, disp_stb, save_done, save_late;
    mmc_pkg::mmc_spi_s spi_o, spi_oe, spi_w;
    mmc_pkg::mmc_state_e mode;
    logic [47:0] disp_kwh;
    logic [87:0] tot;
    logic [31:0] conv;
    int miscompares, check_count, cyc;
    bit run;
    mmc_top #(.NUM_COEF(2), .SPI_HALF(4), .PD_CYCLES(2000)) mmc_top_inst (.clk(clk),
        .rst_n(rst_n), .mode_select_input(strap), .irq_n(irq_n), .sag_n(sag_n),
        .miso(miso), .spi_o(spi_o), .spi_oe(spi_oe), .mode(mode), .disp_kwh(disp_kwh),
        .disp_stb(disp_stb), .save_done(save_done), .save_late(save_late));
    // Board pulls chip selects up, clock and data down
    assign spi_w = (spi_o & spi_oe) | (~spi_oe & 4'h3);
    mmc_far mmc_far_inst (.clk(clk), .spi(spi_w), .miso(miso));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [87:0] got, input logic [87:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            $display("ERROR %0t: timeout", $time);
            results();
        end
    end
    always @(negedge clk)
        if (run && disp_stb === 1'b1)
        begin
            tot = tot + mmc_far_inst.energy * conv;
            check(disp_kwh, tot[87:40]);
        end
    task automatic start(input logic s);
        run = 1'b0;
        rst_n = 1'b0;
        strap = s;
        mmc_far_inst.energy = 24'($urandom);
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
    endtask
    task automatic run_test(input int line);
        int k;
        start(1'b1);
        for (int i = 0; i < 11; i++)
            tot = {tot[79:0], mmc_far_inst.eep[`MMC_EEP_ADDR_TOTAL+i]};
        for (int i = 0; i < 4; i++)
            conv = {conv[23:0], mmc_far_inst.eep[`MMC_EEP_ADDR_CONV+i]};
        run = 1'b1;
        k = check_count + 3;
        for (int n = 0; n < 6000 && check_count < k; n++)
            @(negedge clk);
        check(check_count, k);
        check(mode, mmc_pkg::MMC_ST_RUN_RD);
        for (int i = 0; i < 4; i++)
            check(mmc_far_inst.coef[i], mmc_far_inst.eep[`MMC_EEP_ADDR_COEF+i]);
        if (line == 0)
            irq_n = 1'b0;
        else
            sag_n = 1'b0;
        repeat (400) @(negedge clk);
        irq_n = ~irq_n;
        for (int n = 0; n < 3000 && save_done !== 1'b1; n++)
            @(negedge clk);
        check(save_done, 1'b1);
        check(save_late, 1'b0);
        repeat (20) @(negedge clk);
        check(mode, mmc_pkg::MMC_ST_HALT);
        for (int i = 0; i < 11; i++)
            check(mmc_far_inst.eep[`MMC_EEP_ADDR_SAVE+i], tot[87-8*i -: 8]);
        for (int i = 0; i < 3; i++)
            check(mmc_far_inst.eep[`MMC_EEP_ADDR_SAVE+11+i],
                mmc_far_inst.energy[23-8*i -: 8]);
        irq_n = 1'b1;
        sag_n = 1'b1;
        $display("power-down test on line %0d done", line);
    endtask
    initial
    begin
        rst_n = 1'b0;
        strap = 1'b1;
        irq_n = 1'b1;
        sag_n = 1'b1;
        miscompares = 0;
        check_count = 0;
        cyc = 0;
        run = 1'b0;
        void'($urandom(72978));
        // Host fills the memory once; later starts reload what the save left there
        for (int i = 0; i < 256; i++)
            mmc_far_inst.eep[i] = 8'($urandom);
        start(1'b0);
        repeat (200) @(negedge clk);
        check(mode, mmc_pkg::MMC_ST_CAL);
        check(spi_oe, 4'h0);
        $display("calibration test done");
        run_test(0);
        run_test(1);
        results();
    end
endmodule // testbench
